// >>> sdb_consts.svh
`ifndef SDB_CONSTS_SVH
`define SDB_CONSTS_SVH
// ****************************************
// Register map
// ****************************************
`define SDB_BASE 20'hffff2
`define SDB_OFF_CFG0 12'h000
`define SDB_OFF_WBTO 12'h00c
`define SDB_OFF_CTRL 12'h010
`define SDB_OFF_CMD 12'h014
`define SDB_OFF_STAT 12'h018
// ****************************************
// Reset values
// ****************************************
`define SDB_CFG0_RST 32'h01f00000
`define SDB_WBTO_RST 32'h00000010
// ****************************************
// Field positions
// ****************************************
`define SDB_AP 24
`define SDB_XW 19
`define SDB_B1 7
`define SDB_T1 6
`define SDB_F1 5
`define SDB_B0 3
`define SDB_T0 2
`define SDB_F0 1
`define SDB_CS_BIT 27
`define SDB_CS_TAG 23
`define SDB_CMD_CS 3
`endif

// >>> sdb_ctrl.sv
`include "sdb_consts.svh"
// Function
// - Four-bank x16 non-256M on 16-bit bus: bank selects on lines 12 and 13.
// - 256M on 16-bit bus: banks on lines 13/14, row bits 24:12 on 12:0.
// - 16-bit bus: column phase drives line 0 low.
// - Column phase line 10 carries the auto-precharge setting.
// - Every memory read and write is a quad-word burst, invisible to software.
// - Write buffer has two quad-word halves; one fills while other drains.
// - Active half merges byte, halfword, word writes to same quad word.
// - Flush on write miss, read of merging quad, timeout, or buffer disabled.
// - Write miss swaps halves; old half flushes, new data merges in other.
// - Read of merging quad word waits for write-back before fetching.
// - Each buffer write reloads timeout counter; expiry forces a flush.
// - Read buffer keeps last quad word; hits need no memory access.
// - Write into read-buffered quad word invalidates only the read buffer.
// - Registers sit in a block at the fixed base address.
// - Registers accept word, halfword and byte accesses.
// - Bus width bit: clear is 32-bit (reset), set is 16-bit.
// - Per chip select bit marks two-bank (reset) or four-bank device.
// - Auto-precharge bit resets set; clear means no auto-precharge.
module sdb_ctrl (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host side
    input wire sdb_pkg::sdb_host_req_type host_req,
    output sdb_pkg::sdb_host_rsp_type host_rsp,
    // Memory side
    output sdb_pkg::sdb_mem_req_type mem_req,
    input wire logic mem_ack,
    input wire logic [127:0] mem_rdata
);
    // ****************************************
    // Helpers
    // ****************************************
    sdb_pkg::sdb_state_type q;
    sdb_pkg::sdb_state_type next_q;
    logic [27:0] rtag;
    logic hit_act;
    logic rb_hit;
    logic take;
    logic fl;
    logic mem_rw;
    logic bsel;
    logic fsel;

    assign rtag = host_req.addr[31:4];
    assign hit_act = q.wb_valid[q.act] && (q.wb_tag[q.act] == rtag);
    assign rb_hit = q.rb_valid && (q.rb_tag == rtag);
    assign take = host_req.valid && !q.host.ready;
    assign fl = ~q.act;
    assign mem_rw = q.mem.req && (q.mem.cmd == sdb_pkg::SDB_MC_READ ||
                                  q.mem.cmd == sdb_pkg::SDB_MC_WRITE);
    assign bsel = q.maddr[`SDB_CS_TAG] ? q.cfg0[`SDB_B1] : q.cfg0[`SDB_B0];
    assign fsel = q.maddr[`SDB_CS_TAG] ? q.cfg0[`SDB_F1] : q.cfg0[`SDB_F0];

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign host_rsp = q.host;
    assign mem_req = q.mem;

    // Byte-lane merge so narrow writes leave other lanes intact
    function automatic logic [31:0] bmerge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction : bmerge

    // ****************************************
    // Row and column multiplexing
    // ****************************************
    // Unused lines repeat an address bit or are driven low; the devices ignore them
    function automatic logic [29:0] amux(input logic [31:0] a,
                                         input logic [31:0] c);
        logic cs;
        logic b;
        logic t;
        logic f;
        logic ap;
        logic [14:0] r;
        logic [14:0] k;
        cs = a[`SDB_CS_BIT];
        b = cs ? c[`SDB_B1] : c[`SDB_B0];
        t = cs ? c[`SDB_T1] : c[`SDB_T0];
        f = cs ? c[`SDB_F1] : c[`SDB_F0];
        ap = c[`SDB_AP];
        r = {a[11], a[10], a[11], a[23:12]};
        k = {a[11], a[10], a[11], a[23], ap, a[25], a[24], a[9:2]};
        if (c[`SDB_XW]) begin
            if (f) begin
                r = {a[11], a[10], a[24:12]};
                k = {a[11], a[10], 2'b00, ap, a[25], a[9:2], 1'b0};
            end else if (b && !t) begin
                r = {a[9], a[10], a[9], a[22], a[11], a[21:12]};
                k = {a[9], a[10], a[9], 1'b0, ap, a[24], a[23], a[8:2], 1'b0};
            end else if (b) begin
                r = {a[11], a[10], a[11], a[23:12]};
                k = {a[11], a[10], a[11], 1'b0, ap, a[24], a[9:2], 1'b0};
            end else if (!t) begin
                r = {1'b0, a[9], 1'b0, a[9], a[11], a[10], a[20:12]};
                k = {1'b0, a[9], 1'b0, a[9], ap, a[24], 1'b0, a[8:2], 1'b0};
            end else begin
                r = {1'b0, a[10], 1'b0, a[10], a[11], a[21:12]};
                k = {1'b0, a[10], 1'b0, a[10], ap, a[24], a[9:2], 1'b0};
            end
        end
        return {r, k};
    endfunction : amux

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic swapped;
        logic go;
        logic wr;
        logic [29:0] rc;
        logic [31:0] v;
        swapped = 1'b0;
        go = 1'b0;
        wr = q.act;
        rc = '0;
        v = '0;
        next_q = q;
        next_q.host.ready = 1'b0;
        next_q.pready = 1'b0;
        if (q.wb_valid[q.act] && q.timer != 16'h0000) begin
            next_q.timer = q.timer - 16'h0001;
        end
        // Memory engine: one burst at a time, four words each
        case (q.phase)
            sdb_pkg::SDB_ST_IDLE: begin
                if (q.cmd_pend) begin
                    next_q.cmd_pend = 1'b0;
                    next_q.mem.req = 1'b1;
                    next_q.mem.cmd = q.cmd_code;
                    next_q.mem.cs = q.cmd_cs;
                    next_q.mem.row = q.cmd_row;
                    next_q.mem.col = '0;
                    next_q.phase = sdb_pkg::SDB_ST_CMD;
                end else if (q.flush_pend) begin
                    rc = amux({q.wb_tag[fl], 4'h0}, q.cfg0);
                    next_q.maddr = q.wb_tag[fl];
                    next_q.mem.req = 1'b1;
                    next_q.mem.cmd = sdb_pkg::SDB_MC_WRITE;
                    next_q.mem.cs = q.wb_tag[fl][`SDB_CS_TAG];
                    next_q.mem.row = rc[29:15];
                    next_q.mem.col = rc[14:0];
                    next_q.mem.wdata = q.wb_data[fl];
                    next_q.mem.mask = q.wb_mask[fl];
                    next_q.phase = sdb_pkg::SDB_ST_FLUSH;
                end
            end
            sdb_pkg::SDB_ST_FLUSH: begin
                if (mem_ack) begin
                    next_q.mem.req = 1'b0;
                    next_q.mem.cmd = sdb_pkg::SDB_MC_NOP;
                    next_q.wb_valid[fl] = 1'b0;
                    next_q.wb_mask[fl] = '0;
                    next_q.flush_pend = 1'b0;
                    next_q.phase = sdb_pkg::SDB_ST_IDLE;
                end
            end
            sdb_pkg::SDB_ST_READ: begin
                if (mem_ack) begin
                    next_q.mem.req = 1'b0;
                    next_q.mem.cmd = sdb_pkg::SDB_MC_NOP;
                    next_q.rb_valid = 1'b1;
                    next_q.rb_tag = q.maddr;
                    next_q.rb_data = mem_rdata;
                    next_q.host.ready = 1'b1;
                    next_q.host.rdata = mem_rdata[32*host_req.addr[3:2] +: 32];
                    next_q.phase = sdb_pkg::SDB_ST_IDLE;
                end
            end
            sdb_pkg::SDB_ST_CMD: begin
                if (mem_ack) begin
                    next_q.mem.req = 1'b0;
                    next_q.mem.cmd = sdb_pkg::SDB_MC_NOP;
                    next_q.phase = sdb_pkg::SDB_ST_IDLE;
                end
            end
            default: begin
                next_q.phase = sdb_pkg::SDB_ST_IDLE;
            end
        endcase
        // Host side: writes merge even while the other half drains
        if (take && host_req.write) begin
            if (hit_act || !q.wb_valid[q.act]) begin
                go = 1'b1;
            end else if (!q.flush_pend) begin
                next_q.act = ~q.act;
                next_q.flush_pend = 1'b1;
                swapped = 1'b1;
                wr = ~q.act;
                go = 1'b1;
            end
            // Miss with both halves busy: no answer until drained
            if (go) begin
                next_q.wb_valid[wr] = 1'b1;
                next_q.wb_tag[wr] = rtag;
                for (int i = 0; i < 4; i++) begin
                    if (host_req.strb[i]) begin
                        next_q.wb_data[wr][32*host_req.addr[3:2] + 8*i +: 8] =
                            host_req.wdata[8*i +: 8];
                        next_q.wb_mask[wr][4*host_req.addr[3:2] + i] = 1'b1;
                    end
                end
                next_q.timer = q.wbto[15:0];
                next_q.host.ready = 1'b1;
                if (rb_hit) begin
                    next_q.rb_valid = 1'b0;
                end
            end
        end else if (take) begin
            if (hit_act) begin
                if (!q.flush_pend) begin
                    next_q.act = ~q.act;
                    next_q.flush_pend = 1'b1;
                    swapped = 1'b1;
                end
            end else if (rb_hit) begin
                next_q.host.ready = 1'b1;
                next_q.host.rdata = q.rb_data[32*host_req.addr[3:2] +: 32];
            end else if (q.phase == sdb_pkg::SDB_ST_IDLE && !q.flush_pend &&
                         !q.cmd_pend) begin
                rc = amux({rtag, 4'h0}, q.cfg0);
                next_q.maddr = rtag;
                next_q.mem.req = 1'b1;
                next_q.mem.cmd = sdb_pkg::SDB_MC_READ;
                next_q.mem.cs = rtag[`SDB_CS_TAG];
                next_q.mem.row = rc[29:15];
                next_q.mem.col = rc[14:0];
                next_q.mem.mask = '1;
                next_q.phase = sdb_pkg::SDB_ST_READ;
            end
        end
        // Timeout or disabled buffer pushes the merging half out
        if (!swapped && !go && !q.flush_pend && q.wb_valid[q.act] &&
            (q.timer == 16'h0000 || !q.wb_en)) begin
            next_q.act = ~q.act;
            next_q.flush_pend = 1'b1;
        end
        // Register bus: one wait state, data registered with pready
        if (psel && penable && !q.pready) begin
            next_q.pready = 1'b1;
            next_q.pslverr = 1'b0;
            next_q.prdata = '0;
            if (paddr[31:12] != `SDB_BASE) begin
                next_q.pslverr = 1'b1;
            end else begin
                case (paddr[11:0])
                    `SDB_OFF_CFG0: next_q.prdata = q.cfg0;
                    `SDB_OFF_WBTO: next_q.prdata = q.wbto;
                    `SDB_OFF_CTRL: next_q.prdata = {31'h0, q.wb_en};
                    `SDB_OFF_CMD: next_q.prdata = {1'b0, q.cmd_row, 12'h000,
                                                   q.cmd_cs, q.cmd_code};
                    `SDB_OFF_STAT: next_q.prdata = {27'h0, q.act, q.rb_valid,
                                                    q.wb_valid[q.act],
                                                    q.flush_pend, q.cmd_pend};
                    default: next_q.pslverr = 1'b1;
                endcase
            end
        end
        if (psel && penable && q.pready && pwrite && !q.pslverr) begin
            case (paddr[11:0])
                `SDB_OFF_CFG0: next_q.cfg0 = bmerge(q.cfg0, pwdata, pstrb);
                `SDB_OFF_WBTO: next_q.wbto = bmerge(q.wbto, pwdata, pstrb);
                `SDB_OFF_CTRL: begin
                    v = bmerge({31'h0, q.wb_en}, pwdata, pstrb);
                    next_q.wb_en = v[0];
                end
                `SDB_OFF_CMD: begin
                    // Commands are taken one at a time; a busy write is dropped
                    v = bmerge(32'h0, pwdata, pstrb);
                    if (!q.cmd_pend && v[2:0] >= 3'h3 && v[2:0] <= 3'h5) begin
                        next_q.cmd_pend = 1'b1;
                        next_q.cmd_code = sdb_pkg::sdb_mem_cmd_type'(v[2:0]);
                        next_q.cmd_cs = v[`SDB_CMD_CS];
                        next_q.cmd_row = v[30:16];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.cfg0 <= `SDB_CFG0_RST;
            q.wbto <= `SDB_WBTO_RST;
            q.wb_en <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_col_a0_low: assert property (
        mem_rw && q.cfg0[`SDB_XW] |-> q.mem.col[0] == 1'b0)
        else $error("column line 0 not low on 16-bit bus");
    chk_col_ap_line: assert property (
        $rose(q.mem.req) && mem_rw |-> q.mem.col[10] == $past(q.cfg0[`SDB_AP]))
        else $error("column line 10 does not follow auto-precharge");
    chk_bank_four: assert property (
        mem_rw && q.cfg0[`SDB_XW] && bsel && !fsel
        |-> q.mem.col[13:12] == q.mem.row[13:12] && q.mem.row[13] == q.maddr[6])
        else $error("bank selects not on lines 12 and 13");
    chk_bank_256: assert property (
        mem_rw && q.cfg0[`SDB_XW] && fsel
        |-> q.mem.row[12:0] == q.maddr[20:8] && q.mem.col[14:13] == q.mem.row[14:13])
        else $error("256M mapping wrong");
    // A quad is fetched only once neither the draining nor the merging half holds that same quad
    chk_read_after_wb: assert property (
        $rose(q.mem.req) && q.mem.cmd == sdb_pkg::SDB_MC_READ
        |-> !(q.flush_pend && q.wb_tag[~q.act] == q.maddr) &&
            !(q.wb_valid[q.act] && q.wb_tag[q.act] == q.maddr))
        else $error("read fetched while write-back pending");
    chk_miss_swap: assert property (
        take && host_req.write && !hit_act && q.wb_valid[q.act] && !q.flush_pend
        |=> q.flush_pend && q.act != $past(q.act) && q.host.ready)
        else $error("write miss did not swap halves");
    chk_miss_stall: assert property (
        take && host_req.write && !hit_act && q.wb_valid[q.act] && q.flush_pend
        |=> !q.host.ready)
        else $error("write miss answered while other half busy");
    chk_rb_serve: assert property (
        take && !host_req.write && rb_hit && !hit_act
        |=> q.host.ready && q.phase != sdb_pkg::SDB_ST_READ)
        else $error("read buffer hit went to memory");
    chk_rb_inval: assert property (
        take && host_req.write && rb_hit && !q.wb_valid[q.act]
        |=> !q.rb_valid && q.wb_valid[$past(q.act)])
        else $error("read buffer not invalidated");
    chk_timeout_fire: assert property (
        q.wb_valid[q.act] && q.timer == 16'h0000 && !q.flush_pend && !take &&
        q.phase == sdb_pkg::SDB_ST_IDLE && !q.cmd_pend && !q.pready
        |=> q.flush_pend ##1 q.phase == sdb_pkg::SDB_ST_FLUSH || q.cmd_pend)
        else $error("timeout did not force a flush");
    chk_reg_base: assert property (
        q.pready && !q.pslverr |-> paddr[31:12] == `SDB_BASE)
        else $error("register answered outside its block");

    cov_merge_hit: cover property (take && host_req.write && hit_act);
    cov_merge_during_flush: cover property (
        q.phase == sdb_pkg::SDB_ST_FLUSH && take && host_req.write && hit_act);
    cov_rb_hit: cover property (take && !host_req.write && rb_hit);
    cov_read_wb: cover property (take && !host_req.write && hit_act);
endmodule : sdb_ctrl

// >>> sdb_mem_model.sv
module sdb_mem_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Memory side
    input wire sdb_pkg::sdb_mem_req_type mem_req,
    output logic mem_ack,
    output logic [127:0] mem_rdata,
    // Bench side
    input wire logic [3:0] ack_delay,
    output int n_burst,
    output sdb_pkg::sdb_mem_req_type last_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Burst engine
    // ****************************************
    logic [127:0] store [logic [30:0]];
    logic [127:0] cur;
    logic [30:0] key;
    int wait_cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 128'h0;
            wait_cnt <= 0;
            n_burst <= 0;
            last_req <= '0;
        end else begin
            mem_ack <= 1'b0;
            // Data lines are not valid outside an ack, so never hold the last quad
            mem_rdata <= ~mem_rdata;
            if (mem_req.req && !mem_ack && wait_cnt < ack_delay) begin
                wait_cnt <= wait_cnt + 1;
            end else if (mem_req.req && !mem_ack) begin
                // Line 10 is the precharge flag, not part of the location
                key = {mem_req.cs, mem_req.row, mem_req.col & 15'h7bff};
                cur = store.exists(key) ? store[key] : {4{key, 1'b1}};
                for (int i = 0; i < 16; i++) begin
                    if (mem_req.cmd == sdb_pkg::SDB_MC_WRITE && mem_req.mask[i]) begin
                        cur[8*i+:8] = mem_req.wdata[8*i+:8];
                    end
                end
                store[key] = cur;
                mem_rdata <= cur;
                mem_ack <= 1'b1;
                wait_cnt <= 0;
                n_burst <= n_burst + 1;
                last_req <= mem_req;
            end
        end
    end
endmodule : sdb_mem_model

// >>> sdb_pkg.sv
package sdb_pkg;
    typedef enum logic [2:0] {
        SDB_ST_IDLE = 3'b000,
        SDB_ST_FLUSH = 3'b001,
        SDB_ST_READ = 3'b010,
        SDB_ST_CMD = 3'b011
    } sdb_phase_type;
    typedef enum logic [2:0] {
        SDB_MC_NOP = 3'b000,
        SDB_MC_READ = 3'b001,
        SDB_MC_WRITE = 3'b010,
        SDB_MC_PRECH = 3'b011,
        SDB_MC_REFRESH = 3'b100,
        SDB_MC_MODE = 3'b101
    } sdb_mem_cmd_type;
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] strb;
    } sdb_host_req_type;
    typedef struct packed {
        logic ready;
        logic [31:0] rdata;
    } sdb_host_rsp_type;
    typedef struct packed {
        logic req;
        sdb_mem_cmd_type cmd;
        logic cs;
        logic [14:0] row;
        logic [14:0] col;
        logic [127:0] wdata;
        logic [15:0] mask;
    } sdb_mem_req_type;
    typedef struct packed {
        sdb_phase_type phase;
        logic [31:0] cfg0;
        logic [31:0] wbto;
        logic wb_en;
        logic cmd_pend;
        sdb_mem_cmd_type cmd_code;
        logic cmd_cs;
        logic [14:0] cmd_row;
        logic act;
        logic flush_pend;
        logic [1:0] wb_valid;
        logic [1:0][27:0] wb_tag;
        logic [1:0][127:0] wb_data;
        logic [1:0][15:0] wb_mask;
        logic [15:0] timer;
        logic rb_valid;
        logic [27:0] rb_tag;
        logic [127:0] rb_data;
        logic [27:0] maddr;
        sdb_mem_req_type mem;
        sdb_host_rsp_type host;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sdb_state_type;
endpackage : sdb_pkg

// >>> sdram_buffer_and_address_mux_tb_top.sv
`include "sdb_consts.svh"
module sdram_buffer_and_address_mux_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] addr;
    } sdb_map_row_type;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q, a;
    logic [3:0] pstrb = 4'h0, ack_delay = 4'h0;
    logic pready, pslverr, mem_ack, e;
    logic [127:0] mem_rdata;
    logic [14:0] rm, cm, er, ec;
    sdb_pkg::sdb_host_req_type hreq = '0;
    sdb_pkg::sdb_host_rsp_type host_rsp;
    sdb_pkg::sdb_mem_req_type mem_req, last_req;
    int n_burst, base, n_mismatch = 0, n_compared = 0;
    logic [31:0] cmds [3] = '{32'h04000003, 32'h00000004, 32'h00330005};
    sdb_map_row_type rows [5] = '{'{32'h01f80008, 32'h01234560}, '{32'h01f8000a, 32'h01abcde0},
        '{32'h00f80008, 32'h0055aa50}, '{32'h00f8000a, 32'h01c33c70},
        '{32'h01f800a8, 32'h09abcde0}};
    always #25 pclk = ~pclk;
    sdb_ctrl sdb_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .host_req(hreq), .host_rsp(host_rsp),
        .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    sdb_mem_model sdb_mem_model_inst (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ack_delay(ack_delay), .n_burst(n_burst),
        .last_req(last_req));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic results;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic hang(input int i, input int lim);
        if (i >= lim) begin
            n_mismatch++;
            results();
        end
    endtask : hang
    task automatic apb(input logic wr, input logic [31:0] ad, input logic [31:0] d,
                       input logic [3:0] s);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad[31:12] != 20'h0 ? ad : {`SDB_BASE, ad[11:0]};
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        hang(i, 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic host(input logic wr, input logic [31:0] ad, input logic [31:0] d,
                        input logic [3:0] s);
        int i;
        @(posedge pclk);
        hreq <= '{1'b1, wr, ad, d, s};
        for (i = 0; i < 300; i++) begin
            @(posedge pclk);
            if (host_rsp.ready === 1'b1) break;
        end
        hang(i, 300);
        q = host_rsp.rdata;
        hreq.valid <= 1'b0;
    endtask : host
    task automatic wait_burst(input int n, input int lim);
        int i;
        for (i = 0; i < lim && n_burst < n; i++) begin
            @(posedge pclk);
        end
        hang(i, lim);
    endtask : wait_burst
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SDB_OFF_CFG0, 32'h0, 4'h0);
        check("cfg0_rst", q, `SDB_CFG0_RST);
        check("okay", e, 1'b0);
        apb(1'b0, `SDB_OFF_WBTO, 32'h0, 4'h0);
        check("wbto_rst", q, `SDB_WBTO_RST);
        for (int k = 0; k < 10; k++) begin
            base = n_burst;
            apb(1'b1, `SDB_OFF_CMD, cmds[k == 0 ? 0 : k == 9 ? 2 : 1], 4'hf);
            wait_burst(base + 1, 50);
            check("cmd", last_req.cmd, cmds[k == 0 ? 0 : k == 9 ? 2 : 1][2:0]);
        end
        check("mode_row", last_req.row, 15'h0033);
        apb(1'b1, `SDB_OFF_CFG0, 32'haaaaaaaa, 4'b0010);
        apb(1'b0, `SDB_OFF_CFG0, 32'h0, 4'h0);
        check("byte_wr", q, 32'h01f0aa00);
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        check("pslverr", e, 1'b1);
        apb(1'b0, 32'hfffe2000, 32'h0, 4'h0);
        check("outside", e, 1'b1);
        foreach (rows[r]) begin
            apb(1'b1, `SDB_OFF_CFG0, rows[r].cfg, 4'hf);
            host(1'b0, rows[r].addr, 32'h0, 4'h0);
            a = rows[r].addr;
            check("cs", last_req.cs, a[27]);
            if (rows[r].cfg[a[27] ? `SDB_F1 : `SDB_F0]) begin
                er = {a[11:10], a[24:12]};
                ec = {a[11:10], 2'b00, rows[r].cfg[`SDB_AP], 1'b0, a[9:2], 1'b0};
                rm = 15'h7fff;
                cm = 15'h65ff;
            end else begin
                er = {1'b0, a[10:9], a[22], a[11], a[21:12]};
                ec = {1'b0, a[10:9], 1'b0, rows[r].cfg[`SDB_AP], 2'b00, a[8:2], 1'b0};
                rm = 15'h3fff;
                cm = 15'h34ff;
            end
            check("row", last_req.row & rm, er);
            check("col", last_req.col & cm, ec);
            check("rd_cmd", last_req.cmd, sdb_pkg::SDB_MC_READ);
        end
        apb(1'b1, `SDB_OFF_CFG0, `SDB_CFG0_RST, 4'hf);
        base = n_burst;
        host(1'b1, 32'h1000, 32'h11223344, 4'hf);
        host(1'b1, 32'h1008, 32'h55667788, 4'hf);
        host(1'b1, 32'h100c, 32'h0000ab00, 4'b0010);
        check("merging", n_burst, base);
        host(1'b0, 32'h1008, 32'h0, 4'h0);
        check("merged_rd", q, 32'h55667788);
        check("wb_then_rd", n_burst, base + 2);
        host(1'b0, 32'h100d, 32'h0, 4'h0);
        check("byte_lane", q & 32'h0000ff00, 32'h0000ab00);
        host(1'b0, 32'h1000, 32'h0, 4'h0);
        check("word0", q, 32'h11223344);
        check("rb_hit", n_burst, base + 2);
        host(1'b1, 32'h1004, 32'hcafef00d, 4'hf);
        host(1'b0, 32'h1004, 32'h0, 4'h0);
        check("rb_inval", q, 32'hcafef00d);
        base = n_burst;
        host(1'b1, 32'h2000, 32'h12345678, 4'hf);
        repeat (10) @(posedge pclk);
        check("to_early", n_burst, base);
        wait_burst(base + 1, 40);
        check("to_flush", last_req.cmd, sdb_pkg::SDB_MC_WRITE);
        // Slow memory so that a third quad finds the other half still draining
        ack_delay <= 4'h8;
        base = n_burst;
        for (int j = 0; j < 3; j++) begin
            host(1'b1, 32'h3000 + 16 * j, 32'hd0000000 + j, 4'hf);
        end
        check("stall", n_burst > base, 1'b1);
        for (int j = 0; j < 3; j++) begin
            host(1'b0, 32'h3000 + 16 * j, 32'h0, 4'h0);
            check("swap_rd", q, 32'hd0000000 + j);
        end
        apb(1'b1, `SDB_OFF_CTRL, 32'h0, 4'hf);
        base = n_burst;
        host(1'b1, 32'h4000, 32'h0badcafe, 4'hf);
        wait_burst(base + 1, 20);
        check("dis_flush", last_req.cmd, sdb_pkg::SDB_MC_WRITE);
        results();
    end
endmodule : sdram_buffer_and_address_mux_tb_top
